// ===== core/art_pwm_defines.svh
// register offsets, field positions and reset values of the auto-reload pwm timer
`ifndef ART_PWM_DEFINES_SVH
`define ART_PWM_DEFINES_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define OFS_DUTY3        8'h73
`define OFS_DUTY2        8'h74
`define OFS_DUTY1        8'h75
`define OFS_DUTY0        8'h76
`define OFS_PULSE_CTRL   8'h77
`define OFS_TIMER_CS     8'h78
`define OFS_COUNTER      8'h79
`define OFS_RELOAD       8'h7A
`define OFS_CAPTURE_CS   8'h7B
`define OFS_CAPTURE1     8'h7C
`define OFS_CAPTURE2     8'h7D
`define OFS_WAKE_CTRL    8'h7E

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define BIT_CLK_SRC      7
`define BIT_DIV_HI       6
`define BIT_DIV_LO       4
`define BIT_CNT_EN       3
`define BIT_FORCE_RLD    2
`define BIT_OVF_IE       1
`define BIT_OVF_FLAG     0
`define BIT_CAP_EDGE_LO  4
`define BIT_CAP_IE_LO    2
`define BIT_CAP_FLAG_LO  0
`define BIT_HALT         0

// ----------------------------------------------------------------------------
// reset value and counter top value
// ----------------------------------------------------------------------------
`define RST_REG          8'h00
`define CNT_TOP          8'hFF

`endif

// ===== core/art_pwm_pkg.sv
// types shared by the auto-reload pwm timer
package art_pwm_pkg;
  typedef logic [7:0] byte_t;
endpackage

// ===== core/art_pwm_timer.sv
// 8-bit auto-reload timer with four pwm outputs and two capture channels
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`include "art_pwm_defines.svh"

module art_pwm_timer
  import art_pwm_pkg::*;
#(
  parameter int NUM_PWM = 4,
  parameter int NUM_CAP = 2,
  parameter int PRE_W   = 7
) (
  input  wire logic               i_clk_sys,
  input  wire logic               i_srst,
  input  wire logic               i_ce,
  input  wire logic [7:0]         i_addr,
  input  wire logic [7:0]         i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  output logic      [7:0]         o_rdata,
  input  wire logic               i_ext_clk,
  input  wire logic [NUM_CAP-1:0] i_capture_pin,
  output logic      [NUM_PWM-1:0] o_pulse_output_pin,
  output logic      [NUM_PWM-1:0] o_pulse_output_oe,
  output logic                    o_ovf_irq,
  output logic      [NUM_CAP-1:0] o_cap_irq,
  output logic                    o_wakeup
);

  // the register map and the tap decode are laid out for these sizes only
  if (NUM_PWM != 4 || NUM_CAP != 2 || PRE_W != 7) begin : g_bad_params
    $error("art_pwm_timer: only 4 pwm, 2 capture channels and a 7-bit prescaler are supported");
  end

  // --------------------------------------------------------------------------
  // register state
  // --------------------------------------------------------------------------
  byte_t              timer_ctrl_q;
  logic               ovf_flag_q;
  byte_t              counter_q;
  byte_t              counter_d;
  byte_t              reload_q;
  byte_t              pulse_ctrl_q;
  byte_t              duty_q    [NUM_PWM];
  byte_t              compare_q [NUM_PWM];
  logic [1:0]         cap_edge_q;
  logic [1:0]         cap_ie_q;
  logic [1:0]         cap_flag_q;
  byte_t              capture_q [NUM_CAP];
  logic               halt_q;
  logic [PRE_W-1:0]   pre_q;
  logic [PRE_W-1:0]   pre_d;
  byte_t              rdata_q;

  // --------------------------------------------------------------------------
  // pin synchronisers and edge detection
  // --------------------------------------------------------------------------
  logic [2:0]         ext_sync_q;
  logic [NUM_CAP-1:0] cap_s1_q;
  logic [NUM_CAP-1:0] cap_s2_q;
  logic [NUM_CAP-1:0] cap_s3_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ext_sync_q <= 3'h0;
    end else if (i_ce) begin
      ext_sync_q <= {ext_sync_q[1:0], i_ext_clk};
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      cap_s1_q   <= '0;
      cap_s2_q   <= '0;
      cap_s3_q   <= '0;
    end else if (i_ce) begin
      cap_s1_q   <= i_capture_pin;
      cap_s2_q   <= cap_s1_q;
      cap_s3_q   <= cap_s2_q;
    end
  end

  wire ext_rise = ext_sync_q[1] & ~ext_sync_q[2];

  wire [NUM_CAP-1:0] cap_rise = cap_s2_q & ~cap_s3_q;
  wire [NUM_CAP-1:0] cap_fall = ~cap_s2_q & cap_s3_q;
  wire [NUM_CAP-1:0] cap_edge = (cap_edge_q & cap_rise) | (~cap_edge_q & cap_fall);

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  wire sel_tcs   = (i_addr == `OFS_TIMER_CS);
  wire sel_cnt   = (i_addr == `OFS_COUNTER);
  wire sel_rld   = (i_addr == `OFS_RELOAD);
  wire sel_pctl  = (i_addr == `OFS_PULSE_CTRL);
  wire sel_ccs   = (i_addr == `OFS_CAPTURE_CS);
  wire sel_cap1  = (i_addr == `OFS_CAPTURE1);
  wire sel_cap2  = (i_addr == `OFS_CAPTURE2);
  wire sel_wake  = (i_addr == `OFS_WAKE_CTRL);
  wire sel_duty0 = (i_addr == `OFS_DUTY0);
  wire sel_duty1 = (i_addr == `OFS_DUTY1);
  wire sel_duty2 = (i_addr == `OFS_DUTY2);
  wire sel_duty3 = (i_addr == `OFS_DUTY3);

  wire [NUM_PWM-1:0] sel_duty = {sel_duty3, sel_duty2, sel_duty1, sel_duty0};
  wire [NUM_CAP-1:0] rd_cap   = {sel_cap2, sel_cap1} & {NUM_CAP{i_rd}};

  wire wr_tcs     = i_wr & sel_tcs;
  wire wr_cnt     = i_wr & sel_cnt;
  wire force_rld  = wr_tcs & i_wdata[`BIT_FORCE_RLD];

  // --------------------------------------------------------------------------
  // prescaler and counter
  // --------------------------------------------------------------------------
  wire       clk_src  = timer_ctrl_q[`BIT_CLK_SRC];
  wire [2:0] div_sel  = timer_ctrl_q[`BIT_DIV_HI:`BIT_DIV_LO];
  wire       cnt_en   = timer_ctrl_q[`BIT_CNT_EN];
  wire       in_tick  = clk_src ? ext_rise : 1'b1;

  // tap n fires when the low n bits of the prescaler are all ones
  wire [PRE_W-1:0] tap_mask = PRE_W'((8'h01 << div_sel) - 8'h01);
  wire             pre_tick = in_tick & ((pre_q & tap_mask) == tap_mask);
  wire             cnt_tick = cnt_en & pre_tick;
  wire             overflow = cnt_tick & (counter_q == `CNT_TOP);

  // counter writes and forced reloads restart the prescaler from zero
  always_comb begin
    pre_d = pre_q;
    if (force_rld || wr_cnt) begin
      pre_d = '0;
    end else if (cnt_en && in_tick) begin
      pre_d = pre_q + PRE_W'(1);
    end
  end

  always_comb begin
    counter_d = counter_q;
    if (force_rld) begin
      counter_d = reload_q;
    end else if (wr_cnt) begin
      counter_d = i_wdata;
    end else if (overflow) begin
      counter_d = reload_q;
    end else if (cnt_tick) begin
      counter_d = counter_q + 8'h01;
    end
  end

  // --------------------------------------------------------------------------
  // prescaler and counter state
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      pre_q     <= '0;
      counter_q <= `RST_REG;
    end else if (i_ce) begin
      pre_q     <= pre_d;
      counter_q <= counter_d;
    end
  end

  // --------------------------------------------------------------------------
  // timer control and overflow flag
  // --------------------------------------------------------------------------
  // force reload and the flag never store, force reload reads back zero and the flag reads ovf_flag_q
  wire       ovf_clear = i_rd & sel_tcs;
  wire [7:0] tcs_wval  = {i_wdata[7:3], 1'b0, i_wdata[`BIT_OVF_IE], 1'b0};

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      timer_ctrl_q <= `RST_REG;
    end else if (i_ce && wr_tcs) begin
      timer_ctrl_q <= tcs_wval;
    end
  end

  // a new overflow wins over a clearing read in the same cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ovf_flag_q <= 1'b0;
    end else if (i_ce) begin
      if (overflow) begin
        ovf_flag_q <= 1'b1;
      end else if (ovf_clear) begin
        ovf_flag_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // reload, pulse control and capture control registers
  // --------------------------------------------------------------------------
  wire wr_rld  = i_wr & sel_rld;
  wire wr_pctl = i_wr & sel_pctl;
  wire wr_ccs  = i_wr & sel_ccs;
  wire wr_wake = i_wr & sel_wake;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      reload_q <= `RST_REG;
    end else if (i_ce && wr_rld) begin
      reload_q <= i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      pulse_ctrl_q <= `RST_REG;
    end else if (i_ce && wr_pctl) begin
      pulse_ctrl_q <= i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      cap_edge_q <= 2'h0;
      cap_ie_q   <= 2'h0;
    end else if (i_ce && wr_ccs) begin
      cap_edge_q <= i_wdata[`BIT_CAP_EDGE_LO +: 2];
      cap_ie_q   <= i_wdata[`BIT_CAP_IE_LO +: 2];
    end
  end

  // --------------------------------------------------------------------------
  // halt request, cleared by the wake-up it waits for
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      halt_q <= 1'b0;
    end else if (i_ce) begin
      if (wr_wake) begin
        halt_q <= i_wdata[`BIT_HALT];
      end else if (o_wakeup) begin
        halt_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // pwm channels
  // --------------------------------------------------------------------------
  logic [NUM_PWM-1:0] pwm_raw;

  for (genvar g = 0; g < NUM_PWM; g++) begin : g_pwm
    always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
        duty_q[g]    <= `RST_REG;
        compare_q[g] <= `RST_REG;
      end else if (i_ce) begin
        if (i_wr && sel_duty[g]) begin
          duty_q[g] <= i_wdata;
        end
        if (overflow) begin
          compare_q[g] <= duty_q[g];
        end
      end
    end
    // reload point starts the active phase, the count after the compare match ends it
    assign pwm_raw[g] = (counter_q <= compare_q[g]);
  end

  wire [NUM_PWM-1:0] polarity = pulse_ctrl_q[NUM_PWM-1:0];
  wire [NUM_PWM-1:0] out_en   = pulse_ctrl_q[7:4];

  // polarity applied combinationally so a change shows at once
  assign o_pulse_output_pin = (pwm_raw ^ polarity) & out_en;
  assign o_pulse_output_oe  = out_en;

  // --------------------------------------------------------------------------
  // capture channels
  // --------------------------------------------------------------------------
  for (genvar c = 0; c < NUM_CAP; c++) begin : g_cap
    always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
        capture_q[c]  <= `RST_REG;
        cap_flag_q[c] <= 1'b0;
      end else if (i_ce) begin
        if (cap_edge[c] && !cap_flag_q[c]) begin
          capture_q[c]  <= counter_q;
          cap_flag_q[c] <= 1'b1;
        end else if (rd_cap[c]) begin
          cap_flag_q[c] <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // interrupts and wake-up
  // --------------------------------------------------------------------------
  assign o_ovf_irq = ovf_flag_q & timer_ctrl_q[`BIT_OVF_IE];
  assign o_cap_irq = cap_flag_q & cap_ie_q;
  assign o_wakeup  = halt_q & |(cap_edge & cap_ie_q);

  // --------------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------------
  // each selected register drives its byte, every other one drives zero
  byte_t rd_mux;

  wire [7:0] rv_tcs  = {8{sel_tcs}} & {timer_ctrl_q[7:3], 1'b0, timer_ctrl_q[1], ovf_flag_q};
  wire [7:0] rv_cnt  = {8{sel_cnt}} & counter_q;
  wire [7:0] rv_rld  = {8{sel_rld}} & reload_q;
  wire [7:0] rv_pctl = {8{sel_pctl}} & pulse_ctrl_q;
  wire [7:0] rv_ccs  = {8{sel_ccs}} & {2'b00, cap_edge_q, cap_ie_q, cap_flag_q};
  wire [7:0] rv_cap1 = {8{sel_cap1}} & capture_q[0];
  wire [7:0] rv_cap2 = {8{sel_cap2}} & capture_q[1];
  wire [7:0] rv_wake = {8{sel_wake}} & {7'h00, halt_q};
  wire [7:0] rv_dlo  = ({8{sel_duty0}} & duty_q[0]) | ({8{sel_duty1}} & duty_q[1]);
  wire [7:0] rv_dhi  = ({8{sel_duty2}} & duty_q[2]) | ({8{sel_duty3}} & duty_q[3]);

  assign rd_mux = rv_tcs | rv_cnt | rv_rld | rv_pctl | rv_ccs | rv_cap1 | rv_cap2 | rv_wake | rv_dlo | rv_dhi;

  // read data registered, valid in the cycle after the read strobe
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rdata_q <= `RST_REG;
    end else if (i_ce) begin
      rdata_q <= rd_mux;
    end
  end

  assign o_rdata = rdata_q;

endmodule

// ===== verification/art_pwm_timer_chk.sv
// checker for the auto-reload pwm timer ports
module art_pwm_chk
  import art_pwm_pkg::*;
#(
  parameter int NUM_PWM = 4,
  parameter int NUM_CAP = 2,
  parameter int PRE_W   = 7
) (
  input wire logic               i_clk_sys,
  input wire logic               i_srst,
  input wire logic               i_ce,
  input wire logic [7:0]         i_addr,
  input wire logic [7:0]         i_wdata,
  input wire logic               i_wr,
  input wire logic               i_rd,
  input wire logic [7:0]         o_rdata,
  input wire logic               i_ext_clk,
  input wire logic [NUM_CAP-1:0] i_capture_pin,
  input wire logic [NUM_PWM-1:0] o_pulse_output_pin,
  input wire logic [NUM_PWM-1:0] o_pulse_output_oe,
  input wire logic               o_ovf_irq,
  input wire logic [NUM_CAP-1:0] o_cap_irq,
  input wire logic               o_wakeup
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------------------
  // shadows of written control bits
  // ---------------------------------------------------------------------------
  logic [7:0] ctl_q;
  logic [7:0] pcr_q;
  logic [7:0] ccs_q;
  wire        wr_w  = i_ce && i_wr;
  wire        w77   = wr_w && i_addr == 8'h77;
  wire        r78   = i_ce && i_rd && i_addr == 8'h78;
  wire        r7b   = i_ce && i_rd && i_addr == 8'h7B;
  wire  [3:0] flip_w = (i_wdata[3:0] ^ pcr_q[3:0]) & pcr_q[7:4];
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ctl_q <= 8'h00;
      pcr_q <= 8'h00;
      ccs_q <= 8'h00;
    end else begin
      if (wr_w && i_addr == 8'h78) ctl_q <= i_wdata;
      if (w77) pcr_q <= i_wdata;
      if (wr_w && i_addr == 8'h7B) ccs_q <= i_wdata;
    end
  end
  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  chk_ovf_gated: assert property (o_ovf_irq |-> ctl_q[1])
    else $error("overflow request while disabled");
  chk_oe_copy: assert property (o_pulse_output_oe == pcr_q[7:4])
    else $error("drive enables differ from control");
  chk_pin_gated: assert property ((o_pulse_output_pin & ~o_pulse_output_oe) == 4'h0)
    else $error("pwm level on disabled pin");
  chk_pol_flip: assert property ((w77 && !ctl_q[3] && i_wdata[7:4] == pcr_q[7:4])
    |=> o_pulse_output_pin == ($past(o_pulse_output_pin) ^ $past(flip_w)))
    else $error("polarity change not applied at once");
  chk_cap_gated: assert property ((o_cap_irq & ~ccs_q[3:2]) == 2'b00)
    else $error("capture request while disabled");
  chk_wake_pulse: assert property (o_wakeup && i_ce |-> (|ccs_q[3:2]) ##1 !o_wakeup)
    else $error("wake pulse bad");
  chk_reserved_zero: assert property ($past(r7b) |-> o_rdata[7:6] == 2'b00)
    else $error("reserved capture bits not zero");
  chk_reload_bit_zero: assert property ($past(r78) |-> o_rdata[2] == 1'b0)
    else $error("force reload bit read back");
  chk_reset_clear: assert property ($fell(i_srst) |-> o_rdata == 8'h00 && !o_ovf_irq
    && o_cap_irq == 2'b00 && o_pulse_output_oe == 4'h0 && !o_wakeup)
    else $error("outputs not cleared by reset");
endmodule

bind art_pwm_timer art_pwm_chk #(.NUM_PWM(NUM_PWM), .NUM_CAP(NUM_CAP), .PRE_W(PRE_W)) art_pwm_chk_i (
  .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_clk(i_ext_clk), .i_capture_pin(i_capture_pin),
  .o_pulse_output_pin(o_pulse_output_pin), .o_pulse_output_oe(o_pulse_output_oe),
  .o_ovf_irq(o_ovf_irq), .o_cap_irq(o_cap_irq), .o_wakeup(o_wakeup));

// ===== verification/pin_model.sv
// capture signal sources and external count clock
module pin_model (
  input  wire logic       i_clk_sys,
  input  wire logic [1:0] i_cap_lvl,
  input  wire logic       i_ext_req,
  output logic      [1:0] o_capture_pin = 2'b00,
  output logic            o_ext_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ph_q = 3'h0;
  // one pulse per request, clock stands low between pulses
  always_ff @(posedge i_clk_sys) begin
    o_capture_pin <= i_cap_lvl;
    if (ph_q != 3'h0) ph_q <= ph_q + 3'h1;
    else if (i_ext_req) ph_q <= 3'h1;
  end
  assign o_ext_clk = ph_q[2];
endmodule

// ===== verification/testbench.sv
// register-level tests of the auto-reload pwm timer
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import art_pwm_pkg::*;
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; $display("BAD %0t mismatch got %h exp %h", $time, g, e); end end
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       ce = 1'b1;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       ext_req = 1'b0;
  logic       ext, ovf, wake;
  byte_t      addr = 8'h00;
  byte_t      wdata = 8'h00;
  byte_t      rdata;
  logic [1:0] cap, cirq;
  logic [1:0] cap_lvl = 2'b00;
  logic [3:0] pin, oe;
  byte_t      dv [4] = '{8'hFD, 8'hFC, 8'h00, 8'hFF};
  int         failures = 0;
  int         total_checks = 0;
  int         wakes = 0;
  always #2 clk = ~clk;
  always @(posedge clk) if (wake === 1'b1) wakes++;
  art_pwm_timer art_pwm_timer_i (.i_clk_sys(clk), .i_srst(srst), .i_ce(ce), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_ext_clk(ext), .i_capture_pin(cap), .o_pulse_output_pin(pin),
    .o_pulse_output_oe(oe), .o_ovf_irq(ovf), .o_cap_irq(cirq), .o_wakeup(wake));
  pin_model pin_model_i (.i_clk_sys(clk), .i_cap_lvl(cap_lvl), .i_ext_req(ext_req), .o_capture_pin(cap),
    .o_ext_clk(ext));
  // ---------------------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------------------
  task automatic w(input byte_t a, input byte_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
  endtask
  task automatic r(input byte_t a, input byte_t e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `CHK(rdata, e)
  endtask
  task automatic pins(input logic [1:0] v);
    @(posedge clk);
    cap_lvl <= v;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic end_sim;
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    for (int a = 8'h72; a <= 8'h7F; a++) r(8'(a), 8'h00);
    for (int i = 0; i < 4; i++) begin
      w(8'(8'h73 + i), dv[i]);
      r(8'(8'h73 + i), dv[i]);
    end
    w(8'h7A, 8'hFC);
    r(8'h7A, 8'hFC);
    w(8'h79, 8'h33);
    r(8'h79, 8'h33);
    w(8'h7C, 8'h55);
    r(8'h7C, 8'h00);
    w(8'h78, 8'h06);
    r(8'h79, 8'hFC);
    w(8'h78, 8'h7A);
    repeat (448) @(posedge clk);
    w(8'h78, 8'h72);
    r(8'h79, 8'hFF);
    repeat (300) @(posedge clk);
    r(8'h79, 8'hFF);
    `CHK(ovf, 1'b0)
    w(8'h78, 8'h7A);
    repeat (128) @(posedge clk);
    w(8'h78, 8'h72);
    r(8'h79, 8'hFC);
    `CHK(ovf, 1'b1)
    r(8'h78, 8'h73);
    r(8'h78, 8'h72);
    `CHK(ovf, 1'b0)
    w(8'h77, 8'hF0);
    `CHK(pin, 4'hD)
    w(8'h77, 8'hF5);
    `CHK(pin, 4'h8)
    w(8'h77, 8'h3F);
    `CHK(oe, 4'h3)
    w(8'h76, 8'h00);
    `CHK(pin, 4'h2)
    w(8'h7B, 8'hFC);
    r(8'h7B, 8'h3C);
    pins(2'b01);
    `CHK(cirq, 2'b01)
    r(8'h7B, 8'h3D);
    w(8'h79, 8'h40);
    pins(2'b00);
    pins(2'b01);
    r(8'h7C, 8'hFC);
    `CHK(cirq, 2'b00)
    w(8'h7B, 8'h1C);
    pins(2'b11);
    `CHK(cirq, 2'b00)
    pins(2'b01);
    `CHK(cirq, 2'b10)
    r(8'h7D, 8'h40);
    pins(2'b00);
    w(8'h7E, 8'h01);
    pins(2'b01);
    `CHK(wakes, 1)
    r(8'h7E, 8'h00);
    w(8'h78, 8'h86);
    w(8'h78, 8'h8A);
    repeat (3) begin
      @(posedge clk);
      ext_req <= 1'b1;
      @(posedge clk);
      ext_req <= 1'b0;
      repeat (10) @(posedge clk);
    end
    repeat (6) @(posedge clk);
    w(8'h78, 8'h82);
    r(8'h79, 8'hFF);
    @(posedge clk);
    ce <= 1'b0;
    w(8'h79, 8'h11);
    @(posedge clk);
    ce <= 1'b1;
    r(8'h79, 8'hFF);
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_sim();
  end
endmodule
